// ===== hw/tsom_top.v
/*
 * Test signal observation mux: routes transmit/receive views or digital
 * test signals to the serial observation pin and selects the analog probe.
 * Assumes all stream inputs are generated on clk; host strobe pins are asynchronous.
 */
// Behaviour
// - Route bit 0 shows card traffic chosen by three-bit observe select.
// - Select 0 drives low, 1 drives high, 6 and 7 reserved.
// - Select 3 shows transmit bit stream in NRZ form.
// - Select 2 shows the Miller-coded transmit envelope.
// - Select 4 shows received Manchester signal with subcarrier.
// - Select 5 shows received Manchester signal without subcarrier.
// - Route bit 1 with a non-zero probe code shows digital test signal, observe select ignored.
// - Digital test signal chosen by seven-bit probe field in own register.
// - Probe code F4h shows received bit stream.
// - Probe code E4h shows received-bit and collision valid qualifier.
// - Probe code D4h shows collision flag of current bit.
// - Probe code C4h shows internal serial clock, encoder or receiver.
// - B5h, A5h show synchronized read/write strobes; 96h shows system clock (here a half-rate toggle of it).
// - Probe code 00h falls back to the observe select output.
// - Five-bit analog probe field chooses the node on the analog test pin.
// - Analog codes 0 to C pick the listed nodes in order.
`timescale 1ns/1ns
`include "tsom_defines.vh"

module tsom_top (
	input  wire                      clk,
	input  wire                      resetn,
	input  wire [2:0]                regAddr,
	input  wire [7:0]                regWdata,
	input  wire                      regWr,
	input  wire                      regRd,
	output reg  [7:0]                regRdata,
	input  wire                      txEnvelope,
	input  wire                      txNrz,
	input  wire                      rxManchSub,
	input  wire                      rxManch,
	input  wire                      rxData,
	input  wire                      rxValid,
	input  wire                      rxColl,
	input  wire                      serialClk,
	input  wire                      hostRdN,
	input  wire                      hostWrN,
	output reg                       serialObservePin,
	output wire [`TSOM_AP_NODES-1:0] analogSwitchEn
);

	reg  [2:0] observeSelect_q;
	reg        testRouteBit_q;
	reg  [6:0] digitalProbeSelect_q;
	reg  [4:0] analogProbeSelect_q;
	reg        sysClkHalf_q;
	reg        obs_d;
	reg        testActive_d;
	wire [1:0] hostStrobeLevelN;
	wire       rdSync;
	wire       wrSync;
	wire       analogReserved;
	wire       digitalUnlisted;

	// Listed digital probe codes; every other non-zero code is a factory code.
	function isListedCode;
		input [6:0] code;
		begin
			case (code)
				`TSOM_DP_NONE, `TSOM_DP_RX_DATA, `TSOM_DP_RX_VALID, `TSOM_DP_RX_COLL,
				`TSOM_DP_SERIAL_CLK, `TSOM_DP_RD_SYNC, `TSOM_DP_WR_SYNC,
				`TSOM_DP_SYS_CLK: isListedCode = 1'b1;
				default: isListedCode = 1'b0;
			endcase
		end
	endfunction

	// Digital test signal for a probe code.
	function digitalSignal;
		input [6:0] code;
		input       dData;
		input       dValid;
		input       dColl;
		input       dSclk;
		input       dRd;
		input       dWr;
		input       dSys;
		begin
			case (code)
				`TSOM_DP_RX_DATA:    digitalSignal = dData;
				`TSOM_DP_RX_VALID:   digitalSignal = dValid;
				`TSOM_DP_RX_COLL:    digitalSignal = dColl;
				`TSOM_DP_SERIAL_CLK: digitalSignal = dSclk;
				`TSOM_DP_RD_SYNC:    digitalSignal = dRd;
				`TSOM_DP_WR_SYNC:    digitalSignal = dWr;
				`TSOM_DP_SYS_CLK:    digitalSignal = dSys;
				default:             digitalSignal = 1'b0;
			endcase
		end
	endfunction

	// Host strobe pins are asynchronous, so they pass the three-stage filter.
	tsom_sync #(
		.WIDTH   (2),
		.RST_VAL (2'b11)
	) uHostSync (
		.clk      (clk),
		.resetn   (resetn),
		.pinIn    ({hostWrN, hostRdN}),
		.levelOut (hostStrobeLevelN)
	);

	assign rdSync = ~hostStrobeLevelN[0];
	assign wrSync = ~hostStrobeLevelN[1];

	tsom_analog_sel uAnalogSel (
		.clk         (clk),
		.resetn      (resetn),
		.probeSel    (analogProbeSelect_q),
		.switchEn    (analogSwitchEn),
		.reservedSel (analogReserved)
	);

	assign digitalUnlisted = ~isListedCode(digitalProbeSelect_q);

	// Register writes.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{testRouteBit_q, observeSelect_q} <= `TSOM_RST_CTRL;
			digitalProbeSelect_q <= `TSOM_RST_DIGITAL_PROBE;
			analogProbeSelect_q  <= `TSOM_RST_ANALOG_PROBE;
		end else if (regWr) begin
			case (regAddr)
				`TSOM_OFF_CTRL: begin
					observeSelect_q <= regWdata[`TSOM_CTRL_SEL_MSB:`TSOM_CTRL_SEL_LSB];
					testRouteBit_q  <= regWdata[`TSOM_CTRL_ROUTE_BIT];
				end
				`TSOM_OFF_DIGITAL_PROBE: begin
					digitalProbeSelect_q <= regWdata[6:0];
				end
				`TSOM_OFF_ANALOG_PROBE: begin
					analogProbeSelect_q <= regWdata[4:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Register reads, answered one cycle after the strobe; unmapped reads give zero.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				`TSOM_OFF_CTRL:
					regRdata <= {4'h0, testRouteBit_q, observeSelect_q};
				`TSOM_OFF_DIGITAL_PROBE:
					regRdata <= {1'b0, digitalProbeSelect_q};
				`TSOM_OFF_ANALOG_PROBE:
					regRdata <= {3'h0, analogProbeSelect_q};
				`TSOM_OFF_STATUS:
					regRdata <= {4'h0, digitalUnlisted, analogReserved, testActive_d,
						serialObservePin};
				`TSOM_OFF_SNAPSHOT:
					regRdata <= {rxValid, rxColl, rxData, serialClk, txEnvelope, txNrz,
						wrSync, rdSync};
				default:
					regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

	// The system clock itself cannot leave through a flip-flop, so code 96h
	// shows a half-rate toggle that marks every rising clock edge.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sysClkHalf_q <= 1'b0;
		end else begin
			sysClkHalf_q <= ~sysClkHalf_q;
		end
	end

	// Source selection; nothing here feeds back into transmit, receive or host logic.
	always @* begin
		testActive_d = testRouteBit_q && (digitalProbeSelect_q != `TSOM_DP_NONE);
		obs_d        = 1'b0;
		if (testActive_d) begin
			obs_d = digitalSignal(digitalProbeSelect_q, rxData, rxValid, rxColl,
				serialClk, rdSync, wrSync, sysClkHalf_q);
		end else begin
			case (observeSelect_q)
				`TSOM_OBS_LOW:       obs_d = 1'b0;
				`TSOM_OBS_HIGH:      obs_d = 1'b1;
				`TSOM_OBS_ENVELOPE:  obs_d = txEnvelope;
				`TSOM_OBS_TX_NRZ:    obs_d = txNrz;
				`TSOM_OBS_MANCH_SUB: obs_d = rxManchSub;
				`TSOM_OBS_MANCH:     obs_d = rxManch;
				default:             obs_d = 1'b0;
			endcase
		end
	end

	// The pin is registered to keep it free of select glitches, at one cycle of latency.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			serialObservePin <= 1'b0;
		end else begin
			serialObservePin <= obs_d;
		end
	end

endmodule

// ===== include/tsom_defines.vh
/*
 * Constants of the test signal observation mux: register offsets, field
 * positions, reset values, selector codes and synchroniser depth.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TSOM_DEFINES_VH
`define TSOM_DEFINES_VH

`define TSOM_ADDR_W             3
`define TSOM_DATA_W             8

`define TSOM_OFF_CTRL           3'h0
`define TSOM_OFF_DIGITAL_PROBE  3'h1
`define TSOM_OFF_ANALOG_PROBE   3'h2
`define TSOM_OFF_STATUS         3'h3
`define TSOM_OFF_SNAPSHOT       3'h4

`define TSOM_CTRL_SEL_LSB       0
`define TSOM_CTRL_SEL_MSB       2
`define TSOM_CTRL_ROUTE_BIT     3

`define TSOM_RST_CTRL           4'h0
`define TSOM_RST_DIGITAL_PROBE  7'h00
`define TSOM_RST_ANALOG_PROBE   5'h00

`define TSOM_OBS_LOW            3'h0
`define TSOM_OBS_HIGH           3'h1
`define TSOM_OBS_ENVELOPE       3'h2
`define TSOM_OBS_TX_NRZ         3'h3
`define TSOM_OBS_MANCH_SUB      3'h4
`define TSOM_OBS_MANCH          3'h5

`define TSOM_DP_NONE            7'h00
`define TSOM_DP_RX_DATA         7'h74
`define TSOM_DP_RX_VALID        7'h64
`define TSOM_DP_RX_COLL         7'h54
`define TSOM_DP_SERIAL_CLK      7'h44
`define TSOM_DP_RD_SYNC         7'h35
`define TSOM_DP_WR_SYNC         7'h25
`define TSOM_DP_SYS_CLK         7'h16

`define TSOM_AP_NODES           13
`define TSOM_AP_LAST            5'h0c

`define TSOM_SYNC_STAGES        3

`endif

// ===== hw/tsom_sync.v
/*
 * Three-stage synchroniser with agreement filter for asynchronous pins.
 * Assumes inputs may change at any time relative to clk.
 */
`timescale 1ns/1ns
`include "tsom_defines.vh"

module tsom_sync #(
	parameter WIDTH = 2,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
	input  wire             clk,
	input  wire             resetn,
	input  wire [WIDTH-1:0] pinIn,
	output wire [WIDTH-1:0] levelOut
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : gSync
			reg [`TSOM_SYNC_STAGES-1:0] stage_q;
			reg                         level_q;
			always @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					stage_q <= {`TSOM_SYNC_STAGES{RST_VAL[i]}};
					level_q <= RST_VAL[i];
				end else begin
					stage_q <= {stage_q[1:0], pinIn[i]};
					// Only the second and third stages are compared, the first stays private.
					if (stage_q[1] == stage_q[2]) begin
						level_q <= stage_q[2];
					end
				end
			end
			assign levelOut[i] = level_q;
		end
	endgenerate

endmodule

// ===== hw/tsom_analog_sel.v
/*
 * Analog probe select decoder: one switch enable per internal analog node.
 * Assumes the analog switches sit outside and close while their enable is high.
 */
`timescale 1ns/1ns
`include "tsom_defines.vh"

module tsom_analog_sel (
	input  wire                      clk,
	input  wire                      resetn,
	input  wire [4:0]                probeSel,
	output reg  [`TSOM_AP_NODES-1:0] switchEn,
	output reg                       reservedSel
);

	// Registered so that switch enables never glitch while the code changes.
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			switchEn    <= {`TSOM_AP_NODES{1'b0}};
			reservedSel <= 1'b0;
		end else begin
			reservedSel <= (probeSel > `TSOM_AP_LAST);
			if (probeSel <= `TSOM_AP_LAST) begin
				switchEn <= {{(`TSOM_AP_NODES-1){1'b0}}, 1'b1} << probeSel;
			end else begin
				switchEn <= {`TSOM_AP_NODES{1'b0}};
			end
		end
	end

endmodule

// ===== verif/tsom_top_sva.sv
/* Checker for the test signal observation mux, bound to tsom_top.
   Assumes the writable fields change only through regWr, so it shadows them. */
`timescale 1ns/1ns
`include "tsom_defines.vh"
module tsom_checker (
	input wire logic                      clk,
	input wire logic                      resetn,
	input wire logic [2:0]                regAddr,
	input wire logic [7:0]                regWdata,
	input wire logic                      regWr,
	input wire logic                      txEnvelope,
	input wire logic                      txNrz,
	input wire logic                      rxManchSub,
	input wire logic                      rxManch,
	input wire logic                      rxData,
	input wire logic                      rxValid,
	input wire logic                      rxColl,
	input wire logic                      serialClk,
	input wire logic                      serialObservePin,
	input wire logic [`TSOM_AP_NODES-1:0] analogSwitchEn
);
	logic [3:0] ctrl_q;
	logic [6:0] dp_q;
	logic [4:0] ap_q;
	wire        obs = !ctrl_q[3] || dp_q == 7'h00;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= 4'h0;
			dp_q   <= 7'h00;
			ap_q   <= 5'h00;
		end else if (regWr) begin
			case (regAddr)
				3'h0: ctrl_q <= regWdata[3:0];
				3'h1: dp_q <= regWdata[6:0];
				3'h2: ap_q <= regWdata[4:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_low; obs && ctrl_q[2:0] == 3'h0 |=> !serialObservePin; endproperty
	a_low: assert property (p_low) else $error("pin not low");
	property p_high; obs && ctrl_q[2:0] == 3'h1 |=> serialObservePin; endproperty
	a_high: assert property (p_high) else $error("pin not high");
	property p_env; obs && ctrl_q[2:0] == 3'h2 |=> serialObservePin == $past(txEnvelope); endproperty
	a_env: assert property (p_env) else $error("envelope wrong");
	property p_nrz; obs && ctrl_q[2:0] == 3'h3 |=> serialObservePin == $past(txNrz); endproperty
	a_nrz: assert property (p_nrz) else $error("nrz wrong");
	property p_msub; obs && ctrl_q[2:0] == 3'h4 |=> serialObservePin == $past(rxManchSub); endproperty
	a_msub: assert property (p_msub) else $error("manchester sub wrong");
	property p_man; obs && ctrl_q[2:0] == 3'h5 |=> serialObservePin == $past(rxManch); endproperty
	a_man: assert property (p_man) else $error("manchester wrong");
	property p_data; !obs && dp_q == 7'h74 |=> serialObservePin == $past(rxData); endproperty
	a_data: assert property (p_data) else $error("rx data wrong");
	property p_valid; !obs && dp_q == 7'h64 |=> serialObservePin == $past(rxValid); endproperty
	a_valid: assert property (p_valid) else $error("rx valid wrong");
	property p_coll; !obs && dp_q == 7'h54 |=> serialObservePin == $past(rxColl); endproperty
	a_coll: assert property (p_coll) else $error("collision wrong");
	property p_sclk; !obs && dp_q == 7'h44 |=> serialObservePin == $past(serialClk); endproperty
	a_sclk: assert property (p_sclk) else $error("serial clock wrong");
	property p_rsv; obs && ctrl_q[2:0] > 3'h5 |=> !serialObservePin; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved select not low");
	property p_ana; 1'b1 |=> analogSwitchEn == ($past(ap_q) > 5'h0c ? 13'h0000
		: 13'h0001 << $past(ap_q)); endproperty
	a_ana: assert property (p_ana) else $error("analog switch wrong");
endmodule
bind tsom_top tsom_checker chk_u (.clk, .resetn, .regAddr, .regWdata, .regWr, .txEnvelope,
	.txNrz, .rxManchSub, .rxManch, .rxData, .rxValid, .rxColl, .serialClk, .serialObservePin,
	.analogSwitchEn);

// ===== verif/tsom_scope.sv
/* Scope model on the serial observation pin: counts level changes.
   Assumes the pin is a registered level on clk. */
`timescale 1ns/1ns
module tsom_scope (
	input wire logic clk,
	input wire logic serialObservePin,
	output int       edgeCount
);
	logic last_q = 1'b0;
	initial edgeCount = 0;
	always @(posedge clk) begin
		if (serialObservePin !== last_q) edgeCount <= edgeCount + 1;
		last_q <= serialObservePin;
	end
endmodule

// ===== verif/tb.sv
/* Self-checking bench for tsom_top: reset cases, a table of mux settings, then
   analog, host strobe and clock cases. Assumes checker and scope compiled first. */
`timescale 1ns/1ns
module tb;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [2:0]  regAddr = 3'h0;
	logic [7:0]  regWdata = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [7:0]  regRdata;
	logic [7:0]  src = 8'h00;
	logic [1:0]  hostN = 2'b11;
	logic        pin;
	logic [12:0] sw;
	logic [7:0]  v;
	int          edgeCount, i, n0;
	int          err_total = 0;
	int          compares = 0;
	// Row: control, digital probe, sources {sclk,coll,valid,data,man,msub,nrz,env}, pin.
	logic [19:0] rows [14] = '{{4'h0,7'h00,8'hff,1'b0}, {4'h1,7'h00,8'h00,1'b1},
		{4'h2,7'h00,8'h01,1'b1}, {4'h3,7'h00,8'hfd,1'b0}, {4'h4,7'h00,8'h04,1'b1},
		{4'h5,7'h00,8'hf7,1'b0}, {4'h6,7'h00,8'hff,1'b0}, {4'h7,7'h00,8'hff,1'b0},
		{4'h9,7'h74,8'h10,1'b1}, {4'h8,7'h64,8'hdf,1'b0}, {4'h8,7'h54,8'h40,1'b1},
		{4'h8,7'h44,8'h7f,1'b0}, {4'hb,7'h00,8'h02,1'b1}, {4'hd,7'h25,8'hff,1'b0}};
	always #20 clk = ~clk;
	tsom_top dut_u (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .txEnvelope(src[0]),
		.txNrz(src[1]), .rxManchSub(src[2]), .rxManch(src[3]), .rxData(src[4]),
		.rxValid(src[5]), .rxColl(src[6]), .serialClk(src[7]), .hostRdN(hostN[0]),
		.hostWrN(hostN[1]), .serialObservePin(pin), .analogSwitchEn(sw));
	tsom_scope scope_u (.clk(clk), .serialObservePin(pin), .edgeCount(edgeCount));
	task automatic chk(string what, logic [12:0] e, logic [12:0] s);
		compares++;
		if (e !== s) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(logic [2:0] a);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 v = regRdata;
	endtask
	// The strobe synchroniser latency is not fixed exactly, so wait under a bound.
	task automatic waitPin(logic e);
		for (int n = 0; n < 10 && pin !== e; n++) begin
			@(posedge clk);
			#1;
		end
		chk("strobe pin", e, pin);
	endtask
	task automatic results;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1 chk("analog reset", 13'h0001, sw);
		for (i = 0; i < 4; i++) begin
			rd(i == 3 ? 3'h7 : i[2:0]);
			chk("reset read", 13'h0000, {5'h00, v});
		end
		foreach (rows[i]) begin
			wr(3'h0, {4'h0, rows[i][19:16]});
			wr(3'h1, {1'b0, rows[i][15:9]});
			src <= rows[i][8:1];
			repeat (3) @(posedge clk);
			#1 chk("pin", {12'h000, rows[i][0]}, {12'h000, pin});
		end
		rd(3'h1);
		chk("probe read", 13'h0025, {5'h00, v});
		rd(3'h4);
		chk("snapshot", 13'h00fc, {5'h00, v});
		for (i = 0; i < 13; i++) begin
			wr(3'h2, i[7:0]);
			repeat (2) @(posedge clk);
			#1 chk("analog", i > 12 ? 13'h0000 : 13'h0001 << i, sw);
		end
		for (i = 0; i < 2; i++) begin
			wr(3'h1, i == 0 ? 8'h35 : 8'h25);
			@(posedge clk);
			hostN <= i == 0 ? 2'b10 : 2'b01;
			waitPin(1'b1);
			@(posedge clk);
			hostN <= 2'b11;
			waitPin(1'b0);
		end
		wr(3'h1, 8'h16);
		repeat (2) @(posedge clk);
		#1 n0 = edgeCount;
		repeat (8) @(posedge clk);
		#1 chk("clock toggles", 13'd8, 13'(edgeCount - n0));
		wr(3'h1, 8'h00);
		results();
	end
endmodule
